// >>> design/tsrb_pkg.sv
// Shared constants, types and helpers of the tuner status register bank.
// Assumes a single 25 MHz clock and an AXI4-Lite register bus with 32-bit data.
`default_nettype none

package tsrb_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W         = 8;
    localparam logic [5:0]  IDX_TEST_TWO   = 6'h08;
    localparam logic [5:0]  IDX_BOOT_CFG   = 6'h09;
    localparam logic [5:0]  IDX_STATUS     = 6'h0A;
    localparam logic [5:0]  IDX_CONTROL    = 6'h10;
    localparam logic [5:0]  IDX_IRQ_STAT   = 6'h11;
    localparam logic [5:0]  IDX_IRQ_MASK   = 6'h12;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned STAT_GROUP_BIT = 15;
    localparam int unsigned STAT_STC_BIT   = 14;
    localparam int unsigned STAT_SFBL_BIT  = 13;
    localparam int unsigned STAT_AFC_BIT   = 12;
    localparam int unsigned STAT_SYNC_BIT  = 11;
    localparam int unsigned STAT_BLOCK_A_ERROR_LEVEL_LSB = 9;
    localparam int unsigned STAT_ST_BIT    = 8;
    localparam int unsigned CTRL_SEEK_BIT  = 0;
    localparam int unsigned CTRL_TUNE_BIT  = 1;
    localparam int unsigned CTRL_WRAP_BIT  = 2;
    localparam int unsigned CTRL_VERB_BIT  = 3;
    localparam int unsigned IRQ_STC_BIT    = 0;
    localparam int unsigned IRQ_SFBL_BIT   = 1;
    localparam int unsigned IRQ_GROUP_BIT  = 2;
    localparam int unsigned IRQ_W          = 3;

    // ------------------------------------------------------------
    // Values after reset and limits
    // ------------------------------------------------------------
    localparam logic [15:0] TEST_TWO_RST   = 16'h0000;
    localparam logic [15:0] BOOT_CFG_RST   = 16'h0000;
    localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;
    localparam logic [7:0]  SIGNAL_STRENGTH_LEVEL_CEIL      = 8'h4B;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       seek_done;
        logic       tune_done;
        logic       seek_failed;
        logic       band_limit;
        logic       afc_railed;
        logic       group_ready;
        logic       decoder_sync;
        logic [1:0] block_a_err;
        logic       stereo;
        logic [7:0] signal_strength_level;
    } tsrb_core_in_type;

    typedef struct packed {
        logic seek_req;
        logic tune_req;
        logic seek_wrap_select;
        logic verbose_select;
        logic softmute;
    } tsrb_ctrl_out_type;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic tsrb_is_mapped(input logic [ADDR_W-1:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        return (addr[1:0] == 2'h0) &&
               (idx inside {IDX_TEST_TWO, IDX_BOOT_CFG, IDX_STATUS,
                            IDX_CONTROL, IDX_IRQ_STAT, IDX_IRQ_MASK});
    endfunction

    function automatic logic [15:0] tsrb_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  strb);
        return {strb[1] ? new_v[15:8] : old_v[15:8],
                strb[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

endpackage

`default_nettype wire

// >>> design/tsrb_sticky.sv
// Sticky event flags: hardware sets, software clears by writing ones.
// Assumes set and clear come from logic on the same clock.
`default_nettype none

module tsrb_sticky
    import tsrb_pkg::*;
#(
    parameter int unsigned W = 3
) (
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] flags_o
);

    typedef struct packed {
        logic [W-1:0] flags;
    } tsrb_sticky_state_type;

    tsrb_sticky_state_type r;
    tsrb_sticky_state_type r_nxt;

    // Set beats clear so an event in the clearing cycle is not lost
    always_comb begin
        r_nxt = r;
        r_nxt.flags = (r.flags & ~clr_i) | set_i;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign flags_o = r.flags;

    a_set_beats_clr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i)))
        else $error("sticky flag lost its set");

endmodule

`default_nettype wire

// >>> design/tsrb_top.sv
// Tuner status register bank: reserved test and boot words, the status
// word, a control word, and interrupt status and mask, on AXI4-Lite.
// Assumes the tuner core drives core_i on mclk_i and that done strobes
// are one-cycle pulses.
`default_nettype none

module tsrb_top
    import tsrb_pkg::*;
#(
    parameter logic [7:0] SIGNAL_STRENGTH_LEVEL_MAX = SIGNAL_STRENGTH_LEVEL_CEIL
) (
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    output logic      [1:0]        s_axi_bresp_o,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic      [31:0]       s_axi_rdata_o,
    output logic      [1:0]        s_axi_rresp_o,
    input  wire logic              powered_up_i,
    input  wire tsrb_core_in_type  core_i,
    output var tsrb_ctrl_out_type  ctrl_o,
    output logic                   irq_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_full;
        logic [15:0]       w_data;
        logic [1:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [15:0]       test_two;
        logic [15:0]       boot_cfg;
        logic              seek_req;
        logic              tune_req;
        logic              wrap;
        logic              verbose;
        logic [IRQ_W-1:0]  irq_mask;
        logic              seek_tune_complete;
        logic              sfbl;
        logic              afc;
        logic              group;
        logic              sync;
        logic [1:0]        block_a_error_level;
        logic              stereo;
        logic [7:0]        signal_strength_level;
    } tsrb_state_type;

    tsrb_state_type   r;
    tsrb_state_type   r_nxt;
    logic [15:0]      status_word;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_flags;
    logic             wr_fire;
    logic             stc_set;
    logic             sfbl_set;
    logic             seek_fall;
    logic             tune_fall;

    // ------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------
    // Sync and block A error level read as zero outside verbose mode; group ready always shows
    always_comb begin
        status_word = 16'h0000;
        status_word[STAT_GROUP_BIT] = r.group;
        status_word[STAT_STC_BIT]   = r.seek_tune_complete;
        status_word[STAT_SFBL_BIT]  = r.sfbl;
        status_word[STAT_AFC_BIT]   = r.afc;
        status_word[STAT_SYNC_BIT]  = r.verbose & r.sync;
        status_word[STAT_BLOCK_A_ERROR_LEVEL_LSB +: 2] = r.verbose ? r.block_a_error_level : 2'h0;
        status_word[STAT_ST_BIT]    = r.stereo;
        status_word[7:0]            = r.signal_strength_level;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_nxt   = r;
        irq_clr = '0;
        irq_set = '0;

        // Write address and data are taken independently, one of each
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            r_nxt.aw_full = 1'b1;
            r_nxt.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            r_nxt.w_full = 1'b1;
            r_nxt.w_data = s_axi_wdata_i[15:0];
            r_nxt.w_strb = s_axi_wstrb_i[1:0];
        end
        if (r.bvalid && s_axi_bready_i) begin
            r_nxt.bvalid = 1'b0;
        end

        wr_fire = r.aw_full && r.w_full && !r.bvalid;
        if (wr_fire) begin
            r_nxt.aw_full = 1'b0;
            r_nxt.w_full  = 1'b0;
            r_nxt.bvalid  = 1'b1;
            r_nxt.bresp   = tsrb_is_mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (r.aw_addr[1:0] == 2'h0) begin
                case (r.aw_addr[7:2])
                    // Written while powered up would upset the core
                    IDX_TEST_TWO: begin
                        if (!powered_up_i) begin
                            r_nxt.test_two = tsrb_merge(r.test_two, r.w_data, r.w_strb);
                        end
                    end
                    IDX_BOOT_CFG: begin
                        if (!powered_up_i) begin
                            r_nxt.boot_cfg = tsrb_merge(r.boot_cfg, r.w_data, r.w_strb);
                        end
                    end
                    IDX_CONTROL: begin
                        if (r.w_strb[0]) begin
                            r_nxt.seek_req = r.w_data[CTRL_SEEK_BIT];
                            r_nxt.tune_req = r.w_data[CTRL_TUNE_BIT];
                            r_nxt.wrap     = r.w_data[CTRL_WRAP_BIT];
                            r_nxt.verbose  = r.w_data[CTRL_VERB_BIT];
                        end
                    end
                    IDX_IRQ_STAT: begin
                        if (r.w_strb[0]) begin
                            irq_clr = r.w_data[IRQ_W-1:0];
                        end
                    end
                    IDX_IRQ_MASK: begin
                        if (r.w_strb[0]) begin
                            r_nxt.irq_mask = r.w_data[IRQ_W-1:0];
                        end
                    end
                    // Status word writes are accepted and dropped
                    default: begin
                    end
                endcase
            end
        end

        // Read channel: one read in flight, data from a register
        if (r.rvalid && s_axi_rready_i) begin
            r_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rdata  = 32'h0000_0000;
            r_nxt.rresp  = tsrb_is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr_i[1:0] == 2'h0) begin
                case (s_axi_araddr_i[7:2])
                    IDX_TEST_TWO: r_nxt.rdata[15:0] = r.test_two;
                    IDX_BOOT_CFG: r_nxt.rdata[15:0] = r.boot_cfg;
                    IDX_STATUS:   r_nxt.rdata[15:0] = status_word;
                    IDX_CONTROL: begin
                        r_nxt.rdata[CTRL_SEEK_BIT] = r.seek_req;
                        r_nxt.rdata[CTRL_TUNE_BIT] = r.tune_req;
                        r_nxt.rdata[CTRL_WRAP_BIT] = r.wrap;
                        r_nxt.rdata[CTRL_VERB_BIT] = r.verbose;
                    end
                    IDX_IRQ_STAT: r_nxt.rdata[IRQ_W-1:0] = irq_flags;
                    IDX_IRQ_MASK: r_nxt.rdata[IRQ_W-1:0] = r.irq_mask;
                    default: begin
                    end
                endcase
            end
        end

        // Completion flag: falling request edge clears, completion wins
        seek_fall = r.seek_req && !r_nxt.seek_req;
        tune_fall = r.tune_req && !r_nxt.tune_req;
        stc_set   = core_i.seek_done || core_i.tune_done;
        if (seek_fall || tune_fall) begin
            r_nxt.seek_tune_complete = 1'b0;
        end
        if (stc_set) begin
            r_nxt.seek_tune_complete = 1'b1;
        end

        // Seek fail / band limit depends on wrap select
        sfbl_set = (!r.wrap && core_i.seek_done && core_i.seek_failed) ||
                   (r.wrap && core_i.band_limit);
        if (seek_fall) begin
            r_nxt.sfbl = 1'b0;
        end
        if (sfbl_set) begin
            r_nxt.sfbl = 1'b1;
        end

        // Live fields follow the core every cycle
        r_nxt.afc    = core_i.afc_railed;
        r_nxt.group  = core_i.group_ready;
        r_nxt.sync   = core_i.decoder_sync;
        r_nxt.block_a_error_level  = core_i.block_a_err;
        r_nxt.stereo = core_i.stereo;
        // Clamp rather than wrap: an overrange reading still reads strong
        r_nxt.signal_strength_level   = (core_i.signal_strength_level > SIGNAL_STRENGTH_LEVEL_MAX) ? SIGNAL_STRENGTH_LEVEL_MAX : core_i.signal_strength_level;

        irq_set[IRQ_STC_BIT]   = stc_set;
        irq_set[IRQ_SFBL_BIT]  = sfbl_set;
        irq_set[IRQ_GROUP_BIT] = core_i.group_ready && !r.group;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            r          <= '0;
            r.test_two <= TEST_TWO_RST;
            r.boot_cfg <= BOOT_CFG_RST;
            r.irq_mask <= IRQ_MASK_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    tsrb_sticky #(
        .W (IRQ_W)
    ) u_irq_flags (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (irq_set),
        .clr_i     (irq_clr),
        .flags_o   (irq_flags)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready_o  = !r.aw_full && !r.bvalid;
    assign s_axi_wready_o   = !r.w_full && !r.bvalid;
    assign s_axi_bvalid_o   = r.bvalid;
    assign s_axi_bresp_o    = r.bresp;
    assign s_axi_arready_o  = !r.rvalid;
    assign s_axi_rvalid_o   = r.rvalid;
    assign s_axi_rdata_o    = r.rdata;
    assign s_axi_rresp_o    = r.rresp;
    assign ctrl_o = {r.seek_req,
                     r.tune_req,
                     r.wrap,
                     r.verbose,
                     r.afc};
    assign irq_o = |(irq_flags & r.irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_stc_on_done: assert property (stc_set |=> status_word[STAT_STC_BIT])
        else $error("completion flag not set after done");

    a_stc_req_clear: assert property (
        (seek_fall && !stc_set) |=> !status_word[STAT_STC_BIT])
        else $error("completion flag survived request drop");

    a_sfbl_no_wrap: assert property (
        (!ctrl_o.seek_wrap_select && core_i.seek_done && core_i.seek_failed)
        |=> status_word[STAT_SFBL_BIT])
        else $error("failed seek did not set fail flag");

    a_sfbl_wrap_lim: assert property (
        (ctrl_o.seek_wrap_select && core_i.band_limit) |=> status_word[STAT_SFBL_BIT])
        else $error("band limit did not set fail flag");

    a_sfbl_holds: assert property (
        (status_word[STAT_SFBL_BIT] && !seek_fall) |=> status_word[STAT_SFBL_BIT])
        else $error("fail flag dropped without request low");

    a_afc_softmute: assert property (
        core_i.afc_railed |=> (ctrl_o.softmute && status_word[STAT_AFC_BIT]))
        else $error("rail not reported or audio not softmuted");

    a_afc_tracks: assert property (
        $fell(core_i.afc_railed) |=> !ctrl_o.softmute)
        else $error("rail flag did not follow the core");

    a_group_ready: assert property (
        core_i.group_ready |=> status_word[STAT_GROUP_BIT])
        else $error("group ready not shown");

    a_sync_gated: assert property (
        !ctrl_o.verbose_select |-> !status_word[STAT_SYNC_BIT])
        else $error("sync bit shown outside verbose mode");

    a_block_a_error_level_code: assert property (
        ctrl_o.verbose_select && $stable(ctrl_o.verbose_select)
        |-> status_word[STAT_BLOCK_A_ERROR_LEVEL_LSB +: 2] == $past(core_i.block_a_err))
        else $error("block A level wrong in verbose mode");

    a_signal_strength_level_passes: assert property (
        (core_i.signal_strength_level <= SIGNAL_STRENGTH_LEVEL_MAX) |=> status_word[7:0] == $past(core_i.signal_strength_level))
        else $error("signal strength not passed through");

    a_signal_strength_level_ceiling: assert property (
        (core_i.signal_strength_level > SIGNAL_STRENGTH_LEVEL_MAX) |=> status_word[7:0] == SIGNAL_STRENGTH_LEVEL_MAX)
        else $error("signal strength above ceiling");

    a_status_ro: assert property (
        (wr_fire && r.aw_addr == {IDX_STATUS, 2'h0} && !stc_set && !seek_fall
         && !tune_fall) |=> status_word[STAT_STC_BIT] == $past(r.seek_tune_complete))
        else $error("status word changed by a write");

    a_write_answer: assert property (
        (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o)
        |=> ##1 s_axi_bvalid_o)
        else $error("write answer not given in two cycles");

    c_seek_done: cover property (core_i.seek_done ##1 status_word[STAT_STC_BIT]);
    c_wrap_limit: cover property (ctrl_o.seek_wrap_select && core_i.band_limit);
    c_irq_raise: cover property (!irq_o ##1 irq_o);
    c_status_read: cover property (s_axi_arvalid_i && s_axi_arready_o
                                   && s_axi_araddr_i == {IDX_STATUS, 2'h0});

endmodule

`default_nettype wire

// >>> verification/tsrb_tb_top.sv
// Self-checking bench of the tuner status register bank.
// Assumes a single mclk_i domain; the bench acts as AXI4-Lite master and tuner core.
`default_nettype none

module tsrb_tb_top import tsrb_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;

    logic              mclk    = 1'b0;
    logic              sys_rst = 1'b1;
    logic              awv     = 1'b0;
    logic              wv      = 1'b0;
    logic              bry     = 1'b0;
    logic              arv     = 1'b0;
    logic              rry     = 1'b0;
    logic              pwr     = 1'b0;
    logic [7:0]        awa     = 8'h00;
    logic [7:0]        ara     = 8'h00;
    logic [31:0]       wd      = 32'h0000_0000;
    logic [3:0]        ws      = 4'hF;
    tsrb_core_in_type  core    = '0;
    logic              awr, wrd, bv, arr, rv, irq;
    logic [1:0]        bresp, rresp, r;
    logic [31:0]       rdata;
    logic [15:0]       d;
    tsrb_ctrl_out_type ctrl;
    int                n_fail  = 0;
    int                n_checks = 0;

    tsrb_top u_tsrb_top (
        .mclk_i(mclk), .sys_rst_i(sys_rst),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .powered_up_i(pwr), .core_i(core), .ctrl_o(ctrl), .irq_o(irq)
    );

    initial begin
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    // Handshakes are judged just before the edge, where readys are settled
    task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rs);
        logic ah, wh, bh;
        @(posedge mclk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= {16'h0000, v}; bry <= 1'b1;
        do begin
            @(negedge mclk);
            ah = awv && awr; wh = wv && wrd; bh = bv; rs = bresp;
            @(posedge mclk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
        end while (!bh);
        bry <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic [1:0] rs);
        logic ah, rh;
        @(posedge mclk);
        arv <= 1'b1; ara <= a; rry <= 1'b1;
        do begin
            @(negedge mclk);
            ah = arv && arr; rh = rv; v = rdata[15:0]; rs = rresp;
            @(posedge mclk);
            if (ah) arv <= 1'b0;
        end while (!rh);
        rry <= 1'b0;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic st(input logic [15:0] e);
        rd(8'h28, d, r);
        chk(d, e);
    endtask

    task automatic pls(input logic sd, input logic td, input logic bl);
        @(posedge mclk);
        core.seek_done <= sd; core.tune_done <= td; core.band_limit <= bl;
        @(posedge mclk);
        core.seek_done <= 1'b0; core.tune_done <= 1'b0; core.band_limit <= 1'b0;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reserved words: write back exactly what was read, never while powered up
    task automatic t_reserved;
        rd(8'h20, d, r); chk(d, TEST_TWO_RST);
        wr(8'h20, d, r); chk({14'h0, r}, 16'h0000);
        rd(8'h20, d, r); chk(d, TEST_TWO_RST);
        rd(8'h24, d, r); chk(d, BOOT_CFG_RST);
        wr(8'h24, d, r); chk({14'h0, r}, 16'h0000);
        rd(8'h24, d, r); chk(d, BOOT_CFG_RST);
        st(16'h0000);
        @(posedge mclk) pwr <= 1'b1;
        rd(8'h20, d, r); chk(d, TEST_TWO_RST);
        chk({14'h0, r}, 16'h0000);
        rd(8'h24, d, r); chk(d, BOOT_CFG_RST);
        @(posedge mclk) pwr <= 1'b0;
    endtask

    task automatic t_seek;
        wr(8'h40, 16'h0001, r);
        core.seek_failed <= 1'b1;
        pls(1'b1, 1'b0, 1'b0);
        core.seek_failed <= 1'b0;
        st(16'h6000);
        chk({15'h0, irq}, 16'h0000);                       // masked event stays quiet
        wr(8'h48, 16'h0003, r); chk({15'h0, irq}, 16'h0001);
        wr(8'h40, 16'h0000, r); st(16'h0000);
        wr(8'h44, 16'h0003, r); chk({15'h0, irq}, 16'h0000);
        wr(8'h40, 16'h0005, r);
        chk({11'h0, ctrl}, 16'h0014);                      // control word drives ctrl
        pls(1'b1, 1'b0, 1'b0); st(16'h4000);
        pls(1'b0, 1'b0, 1'b1); st(16'h6000);
        wr(8'h40, 16'h0000, r); st(16'h0000);
        wr(8'h40, 16'h0002, r);
        pls(1'b0, 1'b1, 1'b0); st(16'h4000);
        wr(8'h40, 16'h0000, r); st(16'h0000);
        wr(8'h44, 16'h0007, r);
    endtask

    task automatic t_live;
        logic [7:0] rin [3] = '{8'h4B, 8'h4C, 8'hFF};
        @(posedge mclk);
        core.afc_railed <= 1'b1; core.group_ready <= 1'b1; core.stereo <= 1'b1;
        core.decoder_sync <= 1'b1; core.block_a_err <= 2'h2; core.signal_strength_level <= 8'h30;
        st(16'h9130);
        chk({15'h0, ctrl.softmute}, 16'h0001);
        wr(8'h48, 16'h0004, r); chk({15'h0, irq}, 16'h0001); // group ready raises irq
        wr(8'h40, 16'h0008, r);
        for (int e = 0; e < 4; e++) begin
            @(posedge mclk) core.block_a_err <= e[1:0];
            st(16'h9930 | (16'(e) << 9));
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk) core.signal_strength_level <= rin[i];
            st(16'h9F4B);
        end
        wr(8'h28, 16'h0000, r); chk({14'h0, r}, 16'h0000);
        st(16'h9F4B);
        @(posedge mclk) core.afc_railed <= 1'b0;
        st(16'h8F4B);
        chk({15'h0, ctrl.softmute}, 16'h0000);
        wr(8'h30, 16'h1234, r); chk({14'h0, r}, 16'h0002); // unmapped write
        rd(8'h22, d, r); chk({14'h0, r}, 16'h0002);        // misaligned read
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reserved();
        t_seek();
        t_live();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        close_out();
    end
endmodule

`default_nettype wire
